// ### logic/mob_pkg.sv
// package for the memory ordering and barrier control block
package mob_pkg;

  localparam int OUTST_W = 4;
  localparam logic [OUTST_W-1:0] OUTST_MAX = 4'hF;
  localparam logic [OUTST_W-1:0] OUTST_RST = 4'h0;
  localparam int WORDS_W = 5;
  localparam logic [WORDS_W-1:0] WORDS_RST = 5'h00;

  typedef enum logic [1:0] {
    MOB_NORMAL,
    MOB_DEV_NSH,
    MOB_DEV_SH,
    MOB_STRONG
  } mob_mtype_e;

  typedef enum logic [3:0] {
    MOB_OP_NONE,
    MOB_OP_BYTE_LOAD,
    MOB_OP_HALF_LOAD,
    MOB_OP_WORD_LOAD,
    MOB_OP_LOAD_MULT,
    MOB_OP_STACK_LOAD_MULT,
    MOB_OP_BYTE_STORE,
    MOB_OP_HALF_STORE,
    MOB_OP_WORD_STORE,
    MOB_OP_STORE_MULT,
    MOB_OP_STACK_STORE_MULT,
    MOB_OP_ORDER_BAR,
    MOB_OP_COMPL_BAR,
    MOB_OP_REFETCH_BAR
  } mob_op_e;

  typedef enum logic [1:0] {
    MOB_SZ_BYTE,
    MOB_SZ_HALF,
    MOB_SZ_WORD
  } mob_size_e;

  // one instruction from the execute stage
  typedef struct packed {
    mob_op_e          op;
    mob_mtype_e       mtype;
    logic             implicit_acc;
    logic             speculative;
    logic             pc_in_list;
    logic [31:0]      addr;
    logic [WORDS_W-1:0] words;
  } mob_instr_s;

  // one access presented to the memory system
  typedef struct packed {
    logic        write;
    mob_size_e   size;
    mob_mtype_e  mtype;
    logic [31:0] addr;
  } mob_req_s;

endpackage

// ### logic/mob_order_check.sv
// pairwise ordering decision between an older and a newer access
`timescale 1ns/1ns
module mob_order_check (
  input  wire mob_pkg::mob_mtype_e OLDER,
  input  wire logic                OLDER_VALID,
  input  wire mob_pkg::mob_mtype_e NEWER,
  output logic                     MUST_WAIT
);

  always_comb begin
    MUST_WAIT = 1'b0;
    if (OLDER_VALID) begin
      unique case (OLDER)
        mob_pkg::MOB_DEV_NSH: MUST_WAIT = (NEWER == mob_pkg::MOB_DEV_NSH) ||
                                          (NEWER == mob_pkg::MOB_STRONG);
        mob_pkg::MOB_DEV_SH:  MUST_WAIT = (NEWER == mob_pkg::MOB_DEV_SH) ||
                                          (NEWER == mob_pkg::MOB_STRONG);
        mob_pkg::MOB_STRONG:  MUST_WAIT = (NEWER != mob_pkg::MOB_NORMAL);
        mob_pkg::MOB_NORMAL:  MUST_WAIT = 1'b0;
      endcase
    end
  end

endmodule // mob_order_check

// ### logic/mob_top.sv
// memory ordering and barrier control: issues accesses and retires barriers
`timescale 1ns/1ns
module mob_top (
  input  wire logic                CLK_SYS,
  input  wire logic                NRST,
  input  wire logic                INSTR_VALID,
  input  wire mob_pkg::mob_instr_s INSTR,
  output logic                     INSTR_READY,
  output logic                     MEM_REQ_VALID,
  output mob_pkg::mob_req_s        MEM_REQ,
  input  wire logic                MEM_REQ_READY,
  input  wire logic                MEM_RESP,
  output logic                     EXEC_STALL,
  output logic                     PIPE_FLUSH,
  output logic                     PRED_CTX_UPDATE,
  output logic                     BAR_DONE,
  output logic [3:0]               OUTSTANDING
);

  typedef enum logic [2:0] {
    MOB_IDLE,
    MOB_MULTI,
    MOB_WAIT_ORDER,
    MOB_WAIT_COMPL,
    MOB_FLUSH
  } mob_state_e;

  mob_state_e                 state;
  mob_pkg::mob_instr_s        cur;
  logic [mob_pkg::WORDS_W-1:0] words_left;
  logic [31:0]                word_addr;
  logic [mob_pkg::OUTST_W-1:0] outst;
  mob_pkg::mob_mtype_e        last_type;
  logic                       last_valid;
  mob_pkg::mob_req_s          req;
  logic                       req_valid;
  logic                       done_pulse;
  logic                       flush_pulse;

  logic                       is_mem;
  logic                       is_write;
  logic                       must_wait;
  logic                       order_block;
  logic                       issue;
  logic                       take;
  logic                       resp_dec;
  mob_pkg::mob_size_e         in_size;

  function automatic logic op_is_write(input mob_pkg::mob_op_e op);
    op_is_write = (op == mob_pkg::MOB_OP_BYTE_STORE) ||
                  (op == mob_pkg::MOB_OP_HALF_STORE) ||
                  (op == mob_pkg::MOB_OP_WORD_STORE) ||
                  (op == mob_pkg::MOB_OP_STORE_MULT) ||
                  (op == mob_pkg::MOB_OP_STACK_STORE_MULT);
  endfunction

  function automatic logic op_is_mem(input mob_pkg::mob_op_e op);
    op_is_mem = op_is_write(op) ||
                (op == mob_pkg::MOB_OP_BYTE_LOAD) ||
                (op == mob_pkg::MOB_OP_HALF_LOAD) ||
                (op == mob_pkg::MOB_OP_WORD_LOAD) ||
                (op == mob_pkg::MOB_OP_LOAD_MULT) ||
                (op == mob_pkg::MOB_OP_STACK_LOAD_MULT);
    // no exclusive-access ops exist, atomicity is left to software
  endfunction

  function automatic logic op_is_multi(input mob_pkg::mob_op_e op);
    op_is_multi = (op == mob_pkg::MOB_OP_LOAD_MULT) ||
                  (op == mob_pkg::MOB_OP_STACK_LOAD_MULT) ||
                  (op == mob_pkg::MOB_OP_STORE_MULT) ||
                  (op == mob_pkg::MOB_OP_STACK_STORE_MULT);
  endfunction

  always_comb begin
    unique case (INSTR.op)
      mob_pkg::MOB_OP_BYTE_LOAD,
      mob_pkg::MOB_OP_BYTE_STORE: in_size = mob_pkg::MOB_SZ_BYTE;
      mob_pkg::MOB_OP_HALF_LOAD,
      mob_pkg::MOB_OP_HALF_STORE: in_size = mob_pkg::MOB_SZ_HALF;
      default:                    in_size = mob_pkg::MOB_SZ_WORD;
    endcase
  end

  assign is_mem   = op_is_mem(INSTR.op);
  assign is_write = op_is_write(INSTR.op);

  // newer access against the last device or strongly-ordered one still in flight
  mob_order_check u_order (
    .OLDER       (last_type),
    .OLDER_VALID (last_valid),
    .NEWER       (INSTR.mtype),
    .MUST_WAIT   (must_wait)
  );

  // implicit accesses skip the ordering check; strongly-ordered is never speculative
  assign order_block = !INSTR.implicit_acc && must_wait;

  always_comb begin
    take = 1'b0;
    if (state == MOB_IDLE && INSTR_VALID && !req_valid) begin
      if (!is_mem) begin
        take = 1'b1;
      end else if (INSTR.speculative && INSTR.mtype == mob_pkg::MOB_STRONG) begin
        take = 1'b0;
      end else begin
        take = !order_block;
      end
    end
  end

  assign INSTR_READY = take;
  assign issue       = req_valid && MEM_REQ_READY;
  assign resp_dec    = MEM_RESP && (outst != mob_pkg::OUTST_RST);

  // outstanding transactions, explicit and implicit, complete only on bus response
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      outst <= mob_pkg::OUTST_RST;
    end else if (issue && !resp_dec && outst != mob_pkg::OUTST_MAX) begin
      outst <= outst + 4'h1;
    end else if (!issue && resp_dec) begin
      outst <= outst - 4'h1;
    end
  end

  // type of the youngest in-flight device or strongly-ordered access; cleared once all have responded
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      last_type  <= mob_pkg::MOB_NORMAL;
      last_valid <= 1'b0;
    end else if (issue && !req.mtype[0] && !req.mtype[1]) begin
      last_valid <= last_valid && !(outst == 4'h1 && resp_dec);
    end else if (issue) begin
      last_type  <= req.mtype;
      last_valid <= 1'b1;
    end else if (outst == 4'h1 && resp_dec) begin
      last_valid <= 1'b0;
    end
  end

  // state machine for multi-word transfers and barriers
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      state      <= MOB_IDLE;
      cur        <= '0;
      words_left <= mob_pkg::WORDS_RST;
      word_addr  <= 32'h0000_0000;
      req        <= '0;
      req_valid  <= 1'b0;
    end else begin
      if (issue) begin
        req_valid <= 1'b0;
      end
      unique case (state)
        MOB_IDLE: begin
          if (take && is_mem) begin
            req.write <= is_write;
            req.size  <= in_size;
            req.mtype <= INSTR.mtype;
            req.addr  <= INSTR.addr;
            req_valid <= 1'b1;
            cur       <= INSTR;
            // ascending walk keeps lower word first; pc lists use the same order
            if (op_is_multi(INSTR.op) && INSTR.words > 5'h01) begin
              words_left <= INSTR.words - 5'h01;
              word_addr  <= INSTR.addr + 32'h0000_0004;
              state      <= MOB_MULTI;
            end
          end else if (take && INSTR.op == mob_pkg::MOB_OP_ORDER_BAR) begin
            state <= MOB_WAIT_ORDER;
          end else if (take && INSTR.op == mob_pkg::MOB_OP_COMPL_BAR) begin
            state <= MOB_WAIT_COMPL;
          end else if (take && INSTR.op == mob_pkg::MOB_OP_REFETCH_BAR) begin
            state <= MOB_WAIT_COMPL;
            cur   <= INSTR;
          end
        end
        MOB_MULTI: begin
          if (!req_valid || issue) begin
            req.addr   <= word_addr;
            req_valid  <= 1'b1;
            word_addr  <= word_addr + 32'h0000_0004;
            words_left <= words_left - 5'h01;
            if (words_left == 5'h01) begin
              state <= MOB_IDLE;
            end
          end
        end
        MOB_WAIT_ORDER: begin
          // only load/store traffic from this block is counted, implicit too, so fetch and dma never block
          if (outst == mob_pkg::OUTST_RST && !req_valid) begin
            state <= MOB_IDLE;
          end
        end
        MOB_WAIT_COMPL: begin
          if (outst == mob_pkg::OUTST_RST && !req_valid) begin
            state <= (cur.op == mob_pkg::MOB_OP_REFETCH_BAR) ? MOB_FLUSH : MOB_IDLE;
          end
        end
        MOB_FLUSH: begin
          state <= MOB_IDLE;
        end
      endcase
    end
  end

  // one-cycle completion and flush pulses
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      done_pulse  <= 1'b0;
      flush_pulse <= 1'b0;
    end else begin
      done_pulse  <= (state == MOB_WAIT_COMPL || state == MOB_WAIT_ORDER) &&
                     outst == mob_pkg::OUTST_RST && !req_valid;
      flush_pulse <= state == MOB_WAIT_COMPL && cur.op == mob_pkg::MOB_OP_REFETCH_BAR &&
                     outst == mob_pkg::OUTST_RST && !req_valid;
    end
  end

  assign MEM_REQ_VALID = req_valid;
  assign MEM_REQ       = req;
  // whole pipeline holds during completion wait and flush; order barrier raises no stall but takes no instruction until done
  assign EXEC_STALL    = (state == MOB_WAIT_COMPL) || (state == MOB_FLUSH);
  assign PIPE_FLUSH    = flush_pulse;
  assign PRED_CTX_UPDATE = flush_pulse;
  assign BAR_DONE      = done_pulse;
  assign OUTSTANDING   = outst;

endmodule // mob_top

// ### test/mob_chk_assertions.sv
// port checker for the ordering and barrier block
`timescale 1ns/1ns
module mob_chk_assertions (
  input wire logic                CLK_SYS,
  input wire logic                NRST,
  input wire logic                INSTR_VALID,
  input wire mob_pkg::mob_instr_s INSTR,
  input wire logic                INSTR_READY,
  input wire logic                MEM_REQ_VALID,
  input wire mob_pkg::mob_req_s   MEM_REQ,
  input wire logic                MEM_REQ_READY,
  input wire logic                MEM_RESP,
  input wire logic                EXEC_STALL,
  input wire logic                PIPE_FLUSH,
  input wire logic                PRED_CTX_UPDATE,
  input wire logic                BAR_DONE,
  input wire logic [3:0]          OUTSTANDING
);
  logic [31:0] last_addr;
  logic        fresh;
  default clocking dc @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);
  // a take starts a new transfer, so its first word has no predecessor
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      fresh <= 1'b1;
    end else if (INSTR_VALID && INSTR_READY) begin
      fresh <= 1'b1;
    end else if (MEM_REQ_VALID && MEM_REQ_READY) begin
      fresh <= 1'b0;
    end
  end
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      last_addr <= 32'h0;
    end else if (MEM_REQ_VALID && MEM_REQ_READY) begin
      last_addr <= MEM_REQ.addr;
    end
  end
  sequence s_take_acc;
    INSTR_VALID && INSTR_READY && !INSTR.implicit_acc
    && INSTR.op inside {[mob_pkg::MOB_OP_BYTE_LOAD:mob_pkg::MOB_OP_STACK_STORE_MULT]};
  endsequence
  sequence s_flush;
    PIPE_FLUSH && PRED_CTX_UPDATE && BAR_DONE ##1 !PIPE_FLUSH;
  endsequence
  a_take_issues: assert property (s_take_acc |=> MEM_REQ_VALID)
    else $error("access not offered after take");
  a_req_holds: assert property (MEM_REQ_VALID && !MEM_REQ_READY |=> MEM_REQ_VALID && $stable(MEM_REQ))
    else $error("access changed before acceptance");
  a_no_spec_strong: assert property (INSTR_VALID && INSTR_READY |-> !(INSTR.speculative && INSTR.mtype == mob_pkg::MOB_STRONG))
    else $error("speculative strongly ordered access taken");
  a_stall_no_take: assert property (EXEC_STALL |-> !INSTR_READY)
    else $error("instruction taken during stall");
  a_flush_pulse: assert property (PIPE_FLUSH |-> s_flush)
    else $error("flush pulse malformed");
  a_bar_when_empty: assert property (BAR_DONE |-> $past(OUTSTANDING) == 4'h0)
    else $error("barrier done with accesses pending");
  a_words_ascend: assert property (MEM_REQ_VALID && MEM_REQ_READY && !fresh |-> MEM_REQ.addr == last_addr + 32'h4)
    else $error("word address not ascending by four");
  a_count_up: assert property (MEM_REQ_VALID && MEM_REQ_READY && !MEM_RESP && OUTSTANDING != 4'hF
    |=> OUTSTANDING == $past(OUTSTANDING) + 4'h1)
    else $error("outstanding count not raised");
endmodule // mob_chk_assertions

// ### test/mob_mem_model.sv
// memory system model with settable accept and response delays
`timescale 1ns/1ns
module mob_mem_model (
  input  wire logic       CLK_SYS,
  input  wire logic       NRST,
  input  wire logic       REQ_VALID,
  input  wire logic [3:0] ACC_LAT,
  input  wire logic [3:0] RESP_LAT,
  output logic            REQ_READY,
  output logic            RESP,
  output logic            SIDE_BUSY
);
  logic [3:0] wait_cnt;
  int         cyc;
  int         due_q[$];
  assign REQ_READY = REQ_VALID && (wait_cnt >= ACC_LAT);
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      wait_cnt <= 4'h0;
      RESP <= 1'b0;
      SIDE_BUSY <= 1'b0;
      cyc = 0;
      due_q.delete();
    end else begin
      cyc++;
      wait_cnt <= (REQ_VALID && !REQ_READY) ? wait_cnt + 4'h1 : 4'h0;
      // answer only once the access has taken effect here
      if (REQ_VALID && REQ_READY) due_q.push_back(cyc + int'(RESP_LAT));
      RESP <= 1'b0;
      if (due_q.size() > 0 && due_q[0] <= cyc) begin
        RESP <= 1'b1;
        void'(due_q.pop_front());
      end
      // pollable status: high while any side effect is still pending
      SIDE_BUSY <= (due_q.size() > 0);
    end
  end
endmodule // mob_mem_model

// ### test/mob_top_tb.sv
// self-checking bench for the ordering and barrier block
`timescale 1ns/1ns
module mob_top_tb;
  logic                clk_sys, nrst, instr_valid, instr_ready, req_valid, req_ready;
  logic                mem_resp, exec_stall, pipe_flush, pred_ctx, bar_done, side_busy;
  logic [3:0]          outstanding, acc_lat, resp_lat;
  mob_pkg::mob_instr_s instr;
  mob_pkg::mob_req_s   mem_req;
  mob_pkg::mob_req_s   hs_q[$];
  int                  hs_resp[$];
  int                  num_errors, total_checks, resp_cnt, cycles;
  mob_top DUT (.CLK_SYS(clk_sys), .NRST(nrst), .INSTR_VALID(instr_valid), .INSTR(instr),
    .INSTR_READY(instr_ready), .MEM_REQ_VALID(req_valid), .MEM_REQ(mem_req),
    .MEM_REQ_READY(req_ready), .MEM_RESP(mem_resp), .EXEC_STALL(exec_stall),
    .PIPE_FLUSH(pipe_flush), .PRED_CTX_UPDATE(pred_ctx), .BAR_DONE(bar_done),
    .OUTSTANDING(outstanding));
  mob_mem_model u_mem (.CLK_SYS(clk_sys), .NRST(nrst), .REQ_VALID(req_valid),
    .ACC_LAT(acc_lat), .RESP_LAT(resp_lat), .REQ_READY(req_ready), .RESP(mem_resp),
    .SIDE_BUSY(side_busy));
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      print_verdict();
    end
    if (nrst && req_valid && req_ready) begin
      hs_q.push_back(mem_req);
      hs_resp.push_back(resp_cnt);
    end
    if (nrst && mem_resp) resp_cnt++;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // holds the offer until an edge where ready is high, or gives up
  task automatic issue(mob_pkg::mob_op_e op, mob_pkg::mob_mtype_e mt, logic [31:0] a,
                       logic [4:0] w, logic pc, logic sp, output logic tk);
    int n;
    n = 0;
    instr = '{op, mt, 1'b0, sp, pc, a, w};
    instr_valid = 1'b1;
    @(negedge clk_sys);
    while (instr_ready !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    tk = instr_ready;
    @(posedge clk_sys);
    #1 instr_valid = 1'b0;
  endtask
  task automatic settle();
    int n;
    n = 0;
    while ((outstanding !== 4'h0 || req_valid !== 1'b0 || exec_stall !== 1'b0) && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    #1 chk("side busy", 32'h0, 32'(side_busy));
    hs_q.delete();
    hs_resp.delete();
    resp_cnt = 0;
  endtask
  task automatic t_kinds();
    logic tk;
    for (int i = 0; i < 10; i++) begin
      issue(mob_pkg::mob_op_e'(i + 1), mob_pkg::MOB_NORMAL, 32'h1000 + 32'(i * 8), 5'h01, 1'b0, 1'b0, tk);
      // offer rises at the take edge; with acc_lat 1 the model accepts two edges later
      repeat (3) @(negedge clk_sys);
      chk("count", 32'(i + 1), 32'(hs_q.size()));
      chk("write", 32'(i >= 5), 32'(hs_q[i].write));
      chk("size", (i % 5 > 2) ? 32'h2 : 32'(i % 5), 32'(hs_q[i].size));
      chk("addr", 32'h1000 + 32'(i * 8), hs_q[i].addr);
      @(posedge clk_sys);
      #1;
    end
    settle();
  endtask
  task automatic t_multi();
    logic tk;
    issue(mob_pkg::MOB_OP_STORE_MULT, mob_pkg::MOB_DEV_NSH, 32'h2000, 5'h04, 1'b0, 1'b0, tk);
    issue(mob_pkg::MOB_OP_LOAD_MULT, mob_pkg::MOB_NORMAL, 32'h3000, 5'h03, 1'b1, 1'b0, tk);
    repeat (20) @(posedge clk_sys);
    chk("words", 32'h7, 32'(hs_q.size()));
    for (int i = 0; i < 7; i++) begin
      chk("word addr", i < 4 ? 32'h2000 + 32'(4 * i) : 32'h3000 + 32'(4 * (i - 4)), hs_q[i].addr);
    end
    settle();
  endtask
  // second access is offered while the first still awaits its response
  task automatic t_pair(mob_pkg::mob_mtype_e m1, mob_pkg::mob_mtype_e m2, logic waits);
    logic tk;
    resp_lat = 4'h8;
    issue(mob_pkg::MOB_OP_WORD_STORE, m1, 32'h4000, 5'h01, 1'b0, 1'b0, tk);
    issue(mob_pkg::MOB_OP_WORD_LOAD, m2, 32'h4100, 5'h01, 1'b0, 1'b0, tk);
    repeat (24) @(posedge clk_sys);
    chk("waited", 32'(waits), 32'(hs_resp[1] >= 1));
    settle();
  endtask
  task automatic t_barrier(mob_pkg::mob_op_e bop);
    logic tk, seen;
    int n;
    resp_lat = 4'h6;
    seen = 1'b0;
    n = 0;
    issue(mob_pkg::MOB_OP_WORD_STORE, mob_pkg::MOB_NORMAL, 32'h5000, 5'h01, 1'b0, 1'b0, tk);
    issue(bop, mob_pkg::MOB_NORMAL, 32'h0, 5'h00, 1'b0, 1'b0, tk);
    do begin
      @(negedge clk_sys);
      seen = seen | exec_stall;
      n++;
    end while (bar_done !== 1'b1 && n < 60);
    chk("resp at done", 32'h1, 32'(resp_cnt));
    chk("stall", 32'(bop != mob_pkg::MOB_OP_ORDER_BAR), 32'(seen));
    chk("flush", 32'(bop == mob_pkg::MOB_OP_REFETCH_BAR), 32'(pipe_flush));
    chk("pred ctx", 32'(bop == mob_pkg::MOB_OP_REFETCH_BAR), 32'(pred_ctx));
    @(posedge clk_sys);
    #1 issue(mob_pkg::MOB_OP_WORD_LOAD, mob_pkg::MOB_DEV_SH, 32'h5004, 5'h01, 1'b0, 1'b0, tk);
    chk("take after bar", 32'h1, 32'(tk));
    settle();
  endtask
  initial begin
    clk_sys = 1'b0;
    nrst = 1'b0;
    instr_valid = 1'b0;
    instr = '0;
    acc_lat = 4'h1;
    resp_lat = 4'h2;
    num_errors = 0;
    total_checks = 0;
    resp_cnt = 0;
    cycles = 0;
    repeat (8) @(posedge clk_sys);
    #1 nrst = 1'b1;
    t_kinds();
    t_multi();
    t_pair(mob_pkg::MOB_STRONG, mob_pkg::MOB_DEV_SH, 1'b1);
    t_pair(mob_pkg::MOB_DEV_NSH, mob_pkg::MOB_STRONG, 1'b1);
    t_pair(mob_pkg::MOB_DEV_SH, mob_pkg::MOB_DEV_SH, 1'b1);
    t_pair(mob_pkg::MOB_DEV_NSH, mob_pkg::MOB_NORMAL, 1'b0);
    t_barrier(mob_pkg::MOB_OP_ORDER_BAR);
    t_barrier(mob_pkg::MOB_OP_COMPL_BAR);
    t_barrier(mob_pkg::MOB_OP_REFETCH_BAR);
    print_verdict();
  end
endmodule // mob_top_tb
bind mob_top mob_chk_assertions u_chk (.CLK_SYS(CLK_SYS), .NRST(NRST),
  .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .INSTR_READY(INSTR_READY),
  .MEM_REQ_VALID(MEM_REQ_VALID), .MEM_REQ(MEM_REQ), .MEM_REQ_READY(MEM_REQ_READY),
  .MEM_RESP(MEM_RESP), .EXEC_STALL(EXEC_STALL), .PIPE_FLUSH(PIPE_FLUSH),
  .PRED_CTX_UPDATE(PRED_CTX_UPDATE), .BAR_DONE(BAR_DONE), .OUTSTANDING(OUTSTANDING));
